// ==== core/ccr_core_regs.sv ====
// core control registers: guard key, stack pointer, processor flags, apb slave
// assumes: apb master on pclk; core event inputs are synchronous one-cycle pulses
`default_nettype none
`include "ccr_defs.svh"

module ccr_core_regs #(
  parameter int SP_WIDTH = 16,
  parameter logic [15:0] SRAM_TOP = 16'hffff,
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_retire,
  input wire logic io_write,
  input wire logic nvm_access,
  input wire logic sleep_exec,
  input wire logic set_irq_enable_op,
  input wire logic clear_irq_enable_op,
  input wire logic bit_store_op,
  input wire logic bit_store_val,
  input wire logic alu_flags_we,
  input wire logic [4:0] alu_flags_mask,
  input wire logic [4:0] alu_flags_val,
  input wire logic sp_we,
  input wire logic [15:0] sp_wdata,
  output logic irq_ok,
  output logic guard_io_open,
  output logic guard_spm_open,
  output logic [15:0] stack_top_pointer,
  output logic [7:0] processor_flags
);
  import ccr_pkg::*;

  localparam logic [15:0] SP_MASK = 16'((33'h1 << SP_WIDTH) - 33'h1);

  ccr_state_s s;
  ccr_state_s next_s;
  logic [ADDR_W-3:0] widx;
  logic aligned;
  logic hit_guard;
  logic hit_spl;
  logic hit_sph;
  logic hit_flags;
  logic hit;
  logic setup;
  logic done;
  logic wr_done;
  logic need_wait;
  logic clr_io;
  logic clr_spm;
  logic key_io;
  logic key_spm;

  // ----------------------------------------
  // address decode and apb phases
  // ----------------------------------------
  // registers sit on word indices; the low two address bits must be zero
  assign widx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_guard = aligned && (widx == (ADDR_W-2)'(`CCR_IDX_GUARD));
  assign hit_spl = aligned && (widx == (ADDR_W-2)'(`CCR_IDX_SPL));
  assign hit_sph = aligned && (widx == (ADDR_W-2)'(`CCR_IDX_SPH));
  assign hit_flags = aligned && (widx == (ADDR_W-2)'(`CCR_IDX_FLAGS));
  assign hit = hit_guard || hit_spl || hit_sph || hit_flags;
  assign setup = psel && !penable;
  assign done = psel && penable && s.pready;
  assign wr_done = done && pwrite && !s.pslverr;

  // a bus write that flips the global enable costs one wait state
  assign need_wait = pwrite && hit_flags && (pwdata[`CCR_F_I] != s.flags[`CCR_F_I]);

  // key recognition at the completing edge of a guard write
  assign key_io = wr_done && hit_guard && (pwdata[7:0] == `CCR_KEY_IO);
  assign key_spm = wr_done && hit_guard && (pwdata[7:0] == `CCR_KEY_SPM);

  // the io window also dies on memory writes; the spm window only on nvm or sleep
  assign clr_io = io_write || nvm_access || sleep_exec;
  assign clr_spm = nvm_access || sleep_exec;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;

    // apb answer: data and error are prepared in the setup cycle
    next_s.pready = 1'b0;
    if (setup)
    begin
      next_s.pready = !need_wait;
      next_s.pslverr = !hit;
      next_s.prdata = `CCR_RD_RST;
      if (!pwrite)
      begin
        if (hit_guard)
        begin
          next_s.prdata[`CCR_GUARD_IO] = s.io_open;
          next_s.prdata[`CCR_GUARD_SPM] = s.spm_open;
        end
        if (hit_spl)
          next_s.prdata[15:0] = {8'h00, s.sp[7:0] & SP_MASK[7:0]};
        if (hit_sph)
          next_s.prdata[15:0] = {8'h00, s.tmp};
        if (hit_flags)
          next_s.prdata[15:0] = {8'h00, s.flags};
      end
    end
    else if (psel && penable && !s.pready)
      next_s.pready = 1'b1;

    // low byte read latches the high byte for the following read
    if (done && !pwrite && !s.pslverr && hit_spl)
      next_s.tmp = s.sp[15:8] & SP_MASK[15:8];

    // stack pointer writes: low byte parks, high byte commits both
    if (wr_done && hit_spl)
      next_s.tmp = pwdata[7:0];
    if (wr_done && hit_sph)
      next_s.sp = {pwdata[7:0], s.tmp} & SP_MASK;

    // interrupt hold after a low byte write; any other io write ends it
    if (instr_retire && (s.spcnt != 3'h0))
      next_s.spcnt = s.spcnt - 3'h1;
    if (io_write || (wr_done && !hit_spl))
      next_s.spcnt = 3'h0;
    if (wr_done && hit_spl)
      next_s.spcnt = `CCR_WIN_INSTR;

    // guard window: counts retired instructions, set wins over every clear
    if (instr_retire && (s.io_open || s.spm_open))
    begin
      next_s.gcnt = s.gcnt - 3'h1;
      if (s.gcnt == 3'h1)
      begin
        next_s.io_open = 1'b0;
        next_s.spm_open = 1'b0;
      end
    end
    if (clr_io)
      next_s.io_open = 1'b0;
    if (clr_spm)
      next_s.spm_open = 1'b0;
    if (key_io || key_spm)
    begin
      next_s.gcnt = `CCR_WIN_INSTR;
      next_s.io_open = key_io;
      next_s.spm_open = key_spm;
    end

    // core push, pop and call traffic outranks a same-cycle bus write
    if (sp_we)
      next_s.sp = sp_wdata & SP_MASK;

    // flags: bus write first, then core updates per bit
    if (wr_done && hit_flags)
      next_s.flags = pwdata[7:0];
    if (bit_store_op)
      next_s.flags[`CCR_F_T] = bit_store_val;
    if (alu_flags_we)
    begin
      if (alu_flags_mask[`CCR_ALU_H])
        next_s.flags[`CCR_F_H] = alu_flags_val[`CCR_ALU_H];
      for (int i = 0; i < 4; i++)
      begin
        if (alu_flags_mask[i])
          next_s.flags[i] = alu_flags_val[i];
      end
    end
    // sign is never stored independently, so it cannot disagree
    next_s.flags[`CCR_F_S] = next_s.flags[`CCR_F_N] ^ next_s.flags[`CCR_F_V];
    // enable flag changes only by op or write; nothing here clears it on entry
    if (set_irq_enable_op)
      next_s.flags[`CCR_F_I] = 1'b1;
    if (clear_irq_enable_op)
      next_s.flags[`CCR_F_I] = 1'b0;

    // interrupt permission seen by the interrupt controller
    next_s.irq_ok = next_s.flags[`CCR_F_I] && !next_s.io_open
      && !next_s.spm_open && (next_s.spcnt == 3'h0);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s.io_open <= 1'b0;
      s.spm_open <= 1'b0;
      s.gcnt <= 3'h0;
      s.spcnt <= 3'h0;
      s.sp <= SRAM_TOP & SP_MASK;
      s.tmp <= `CCR_TMP_RST;
      s.flags <= `CCR_FLAGS_RST;
      s.pready <= 1'b0;
      s.pslverr <= 1'b0;
      s.prdata <= `CCR_RD_RST;
      s.irq_ok <= 1'b0;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq_ok = s.irq_ok;
  assign guard_io_open = s.io_open;
  assign guard_spm_open = s.spm_open;
  assign stack_top_pointer = s.sp;
  assign processor_flags = s.flags;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait_setup;
    setup && need_wait;
  endsequence

  sequence s_one_wait;
    !pready ##1 pready;
  endsequence

  sequence s_spl_write;
    wr_done && hit_spl && !io_write;
  endsequence

  chk_wait_state_len: assert property (
    s_wait_setup |=> s_one_wait)
    else $error("enable change did not take exactly one wait state");

  chk_no_wait_plain: assert property (
    setup && !need_wait |=> pready)
    else $error("plain access was stalled");

  chk_key_opens_io: assert property (
    key_io |=> guard_io_open && !guard_spm_open)
    else $error("io key did not open io window");

  chk_window_expires: assert property (
    (guard_io_open || guard_spm_open) && instr_retire && s.gcnt == 3'h1
      && !key_io && !key_spm |=> !guard_io_open && !guard_spm_open)
    else $error("window outlived four instructions");

  chk_window_hold_irq: assert property (
    guard_io_open || guard_spm_open |-> !irq_ok)
    else $error("interrupt allowed during guard window");

  chk_guard_read_zero: assert property (
    done && !pwrite && hit_guard |-> prdata[31:2] == 30'h0)
    else $error("guard upper bits not zero");

  chk_sp_unused_zero: assert property (
    (stack_top_pointer & ~SP_MASK) == 16'h0000)
    else $error("unimplemented stack bits set");

  // a core memory write one cycle later legally ends the hold, so it excuses the second cycle
  chk_spl_hold_irq: assert property (
    s_spl_write |=> !irq_ok ##1 (!irq_ok || $past(io_write)))
    else $error("interrupt allowed right after low byte write");

  chk_sph_commit: assert property (
    wr_done && hit_sph && !sp_we |=>
      stack_top_pointer == ({$past(pwdata[7:0]), $past(s.tmp)} & SP_MASK))
    else $error("high byte write did not commit pair");

  chk_sign_xor: assert property (
    processor_flags[`CCR_F_S] == (processor_flags[`CCR_F_N] ^ processor_flags[`CCR_F_V]))
    else $error("sign flag disagrees");

  chk_enable_fall: assert property (
    $fell(processor_flags[`CCR_F_I]) |->
      $past(clear_irq_enable_op) || ($past(wr_done) && $past(hit_flags)))
    else $error("enable flag cleared without cause");

  chk_set_op: assert property (
    set_irq_enable_op && !clear_irq_enable_op |=> processor_flags[`CCR_F_I])
    else $error("set op did not raise enable");

  chk_bit_store: assert property (
    bit_store_op |=> processor_flags[`CCR_F_T] == $past(bit_store_val))
    else $error("bit store not captured");

  chk_half_carry: assert property (
    alu_flags_we && alu_flags_mask[`CCR_ALU_H] |=>
      processor_flags[`CCR_F_H] == $past(alu_flags_val[`CCR_ALU_H]))
    else $error("half carry not updated");

  chk_sleep_close: assert property (
    sleep_exec && !key_io && !key_spm |=> !guard_io_open && !guard_spm_open)
    else $error("sleep did not close window");

  // the spm key must open only its own window; a stale io bit would unlock registers
  chk_key_opens_spm: assert property (
    key_spm |=> guard_spm_open && !guard_io_open)
    else $error("spm key did not open spm window");

  chk_io_write_close: assert property (
    io_write && !key_io && !key_spm |=> !guard_io_open)
    else $error("memory write did not close io window");

  chk_nvm_close: assert property (
    nvm_access && !key_io && !key_spm |=> !guard_io_open && !guard_spm_open)
    else $error("nvm access did not close window");

  // reads never wait, so the data reflects the window state of the setup cycle
  chk_guard_read_bits: assert property (
    done && !pwrite && hit_guard && !pslverr |->
      prdata[1] == $past(guard_spm_open) && prdata[0] == $past(guard_io_open))
    else $error("guard readback bits wrong");

  chk_irq_needs_enable: assert property (
    irq_ok |-> processor_flags[`CCR_F_I])
    else $error("interrupt allowed with enable flag clear");

  chk_sp_hold_blocks: assert property (
    s.spcnt != 3'h0 |-> !irq_ok)
    else $error("interrupt allowed during stack hold");

  chk_bad_addr_err: assert property (
    setup && !hit |=> pslverr)
    else $error("unmapped access not refused");

  chk_clear_op: assert property (
    clear_irq_enable_op |=> !processor_flags[`CCR_F_I])
    else $error("clear op did not drop enable");

  chk_spl_park: assert property (
    wr_done && hit_spl |=> s.tmp == $past(pwdata[7:0]))
    else $error("low byte write not parked");

  // a same-cycle enable op would win, so only plain writes are held to the bus value
  chk_flags_write_en: assert property (
    wr_done && hit_flags && !set_irq_enable_op && !clear_irq_enable_op |=>
      processor_flags[`CCR_F_I] == $past(pwdata[`CCR_F_I]))
    else $error("enable flag write lost");

  chk_sp_core_write: assert property (
    sp_we |=> stack_top_pointer == ($past(sp_wdata) & SP_MASK))
    else $error("core stack update lost");

endmodule
`default_nettype wire

// ==== pkg/ccr_defs.svh ====
// register indices, key values, bit positions and counts of the core control registers
// assumes: included by bare name; defines only
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
// register word indices (byte address is four times the index)
`define CCR_IDX_GUARD 8'h04
`define CCR_IDX_SPL 8'h0d
`define CCR_IDX_SPH 8'h0e
`define CCR_IDX_FLAGS 8'h0f
// guard keys
`define CCR_KEY_SPM 8'h9d
`define CCR_KEY_IO 8'hd8
// guard readback bits
`define CCR_GUARD_IO 0
`define CCR_GUARD_SPM 1
// instruction windows and wait states
`define CCR_WIN_INSTR 3'h4
`define CCR_WAIT_CYCLES 1
// processor flag bit positions
`define CCR_F_I 7
`define CCR_F_T 6
`define CCR_F_H 5
`define CCR_F_S 4
`define CCR_F_V 3
`define CCR_F_N 2
`define CCR_F_Z 1
`define CCR_F_C 0
// alu flag vector slot of the half carry
`define CCR_ALU_H 4
// reset values
`define CCR_FLAGS_RST 8'h00
`define CCR_TMP_RST 8'h00
`define CCR_RD_RST 32'h0000_0000
`endif

// ==== pkg/ccr_pkg.sv ====
// types shared by the core control register bank
// assumes: compiled before the core module
`default_nettype none
package ccr_pkg;
  // whole state of the register bank
  typedef struct packed {
    logic io_open;
    logic spm_open;
    logic [2:0] gcnt;
    logic [2:0] spcnt;
    logic [15:0] sp;
    logic [7:0] tmp;
    logic [7:0] flags;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_ok;
  } ccr_state_s;
endpackage
`default_nettype wire

// ==== dv/ccr_core_model.sv ====
// core side model: pulses execution events into the register bank
// assumes: the bench calls ev() between bus transfers; pclk runs free
`default_nettype none
module ccr_core_model (
  input wire logic pclk,
  output logic instr_retire,
  output logic io_write,
  output logic nvm_access,
  output logic sleep_exec,
  output logic set_irq_enable_op,
  output logic clear_irq_enable_op,
  output logic bit_store_op,
  output logic bit_store_val,
  output logic alu_flags_we,
  output logic [4:0] alu_flags_mask,
  output logic [4:0] alu_flags_val,
  output logic sp_we,
  output logic [15:0] sp_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // event pulses
  // ------
  initial
  begin
    {instr_retire, io_write, nvm_access, sleep_exec, sp_we} = 5'h00;
    {set_irq_enable_op, clear_irq_enable_op, bit_store_op, alu_flags_we} = 4'h0;
    {bit_store_val, alu_flags_mask, alu_flags_val, sp_wdata} = 27'h000_0000;
  end
  // one pulse per call; value and stack data lines flip when released, the mask holds, so stale values never pass
  task ev(input logic [8:0] e, input logic [15:0] d);
    @(posedge pclk);
    {sp_we, alu_flags_we, bit_store_op} <= e[8:6];
    {clear_irq_enable_op, set_irq_enable_op} <= e[5:4];
    {sleep_exec, nvm_access, io_write, instr_retire} <= e[3:0];
    bit_store_val <= d[0];
    alu_flags_mask <= d[12:8];
    alu_flags_val <= d[4:0];
    sp_wdata <= d;
    @(posedge pclk);
    {sp_we, alu_flags_we, bit_store_op, clear_irq_enable_op} <= 4'h0;
    {set_irq_enable_op, sleep_exec, nvm_access, io_write, instr_retire} <= 5'h00;
    {bit_store_val, alu_flags_val, sp_wdata} <= ~{d[0], d[4:0], d};
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench of the core control register bank over apb
// assumes: bank and core model on one pclk domain; stack pointer cut to 10 bits
`default_nettype none
`include "ccr_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_G = {2'b00, `CCR_IDX_GUARD, 2'b00};
  localparam logic [11:0] A_L = {2'b00, `CCR_IDX_SPL, 2'b00};
  localparam logic [11:0] A_H = {2'b00, `CCR_IDX_SPH, 2'b00};
  localparam logic [11:0] A_F = {2'b00, `CCR_IDX_FLAGS, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ex;
  logic instr_retire, io_write, nvm_access, sleep_exec, sp_we, bit_store_op, bit_store_val;
  logic set_irq_enable_op, clear_irq_enable_op, alu_flags_we, guard_io_open, guard_spm_open;
  logic [4:0] alu_flags_mask, alu_flags_val;
  logic [15:0] sp_wdata, stack_top_pointer, r;
  logic [7:0] processor_flags, f;
  logic [31:0] q[$];
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  ccr_core_regs #(.SP_WIDTH(10), .SRAM_TOP(16'h03ff)) uut (.*);
  ccr_core_model core (.*);
  // ------
  // clock, timeout and read monitor
  // ------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  // oldest note against each completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      ex = q.pop_front();
      `CHK(prdata, ex)
    end
  end
  // ------
  // helpers
  // ------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // for reads d is the expected data; waits on pready, never a fixed count
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    `CHK(pslverr, e)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chki(input logic e);
    @(negedge pclk);
    `CHK(irq_ok, e)
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ------
  // main sequence
  // ------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    f = 8'h00;
    r = 16'd28393;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_F, 0, 0);
    apb(0, A_G, 0, 0);
    apb(0, A_L, 32'h0000_00ff, 0);
    apb(0, A_H, 32'h0000_0003, 0);
    apb(1, A_F, 32'h0000_0080, 0);
    f = 8'h80;
    chki(1);
    apb(1, A_G, {24'h0, `CCR_KEY_IO}, 0);
    apb(0, A_G, 1, 0);
    chki(0);
    `CHK({guard_spm_open, guard_io_open}, 2'b01)
    repeat (3) core.ev(9'h001, 0);
    apb(0, A_G, 1, 0);
    core.ev(9'h001, 0);
    apb(0, A_G, 0, 0);
    chki(1);
    apb(1, A_G, {24'h0, `CCR_KEY_SPM}, 0);
    apb(0, A_G, 2, 0);
    `CHK({guard_spm_open, guard_io_open}, 2'b10)
    core.ev(9'h002, 0);
    apb(0, A_G, 2, 0);
    core.ev(9'h004, 0);
    apb(0, A_G, 0, 0);
    apb(1, A_G, {24'h0, `CCR_KEY_IO}, 0);
    core.ev(9'h008, 0);
    apb(0, A_G, 0, 0);
    r = lfsr(r);
    apb(1, A_G, {25'h0, r[6:0]}, 0);
    apb(0, A_G, 0, 0);
    // low byte write holds interrupts for four retires
    r = lfsr(r);
    apb(1, A_L, {24'h0, r[7:0]}, 0);
    chki(0);
    repeat (3) core.ev(9'h001, 0);
    chki(0);
    core.ev(9'h001, 0);
    chki(1);
    apb(1, A_H, {24'h0, r[15:8]}, 0);
    apb(0, A_L, {24'h0, r[7:0]}, 0);
    apb(0, A_H, {30'h0, r[9:8]}, 0);
    `CHK(stack_top_pointer, {6'h0, r[9:0]})
    apb(1, A_L, 32'h0000_0055, 0);
    chki(0);
    core.ev(9'h002, 0);
    chki(1);
    core.ev(9'h100, 16'hffff);
    apb(0, A_L, 32'h0000_00ff, 0);
    apb(0, A_H, 32'h0000_0003, 0);
    // random alu flag updates under random masks
    repeat (8)
    begin
      r = lfsr(r);
      core.ev(9'h080, r);
      f[5] = r[12] ? r[4] : f[5];
      f[3] = r[11] ? r[3] : f[3];
      f[2] = r[10] ? r[2] : f[2];
      f[1] = r[9] ? r[1] : f[1];
      f[0] = r[8] ? r[0] : f[0];
      f[4] = f[2] ^ f[3];
      @(negedge pclk);
      `CHK(processor_flags, f)
    end
    apb(0, A_F, {24'h0, f}, 0);
    core.ev(9'h040, 16'h0001);
    f[6] = 1'b1;
    apb(0, A_F, {24'h0, f}, 0);
    core.ev(9'h020, 0);
    f[7] = 1'b0;
    apb(0, A_F, {24'h0, f}, 0);
    chki(0);
    core.ev(9'h010, 0);
    chki(1);
    core.ev(9'h001, 0);
    chki(1);
    apb(0, 12'h014, 0, 1);
    apb(0, 12'h011, 0, 1);
    results();
  end
endmodule
`default_nettype wire
